// [hw/two_wire_debug_unit.sv]
// Slave end of the two-wire serial debug link
`timescale 1ns/1ps
`default_nettype none

module two_wire_debug_unit (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// Serial link pins
	input  wire logic                        debug_serial_clock,
	input  wire logic                        debug_serial_data_in,
	output logic                             debug_serial_data_out,
	output logic                             debug_serial_data_oe,
	// External bus arbitration pins
	input  wire logic                        bus_request_in,
	output logic                             bus_grant_out,
	// Debug register access toward the core
	output debug_link_pkg::reg_write_t       reg_write,
	output debug_link_pkg::reg_read_t        reg_read,
	input  wire logic [7:0]                  reg_read_data,
	// Processor control
	input  wire logic                        break_request,
	output logic                             cpu_halt,
	output logic                             pc_advance_two,
	// Status
	output logic                             bus_grant_allow,
	output logic                             link_busy
);

	// --------------------------------------------------
	// State
	// --------------------------------------------------
	typedef struct packed {
		debug_link_pkg::link_state_t fsm;
		logic [3:0]                  bit_cnt;
		logic [7:0]                  shifter;
		logic [6:0]                  reg_addr;
		logic                        dir_read;
		logic                        busy;
		logic                        allow;
		logic                        grant;
		logic                        sda_out;
		logic                        sda_oe;
		logic                        wr_stb;
		logic [6:0]                  wr_addr;
		logic [7:0]                  wr_data;
		logic                        rd_stb;
		logic                        pc_step;
		logic                        halt;
	} unit_state_t;

	unit_state_t st;
	unit_state_t next_st;

	// --------------------------------------------------
	// Pin sampling
	// --------------------------------------------------
	logic [2:0] line_now;
	logic [2:0] line_prev;

	line_sampler u_sampler (
		.clk        (clk),
		.reset      (reset),
		.raw        ({bus_request_in, debug_serial_data_in, debug_serial_clock}),
		.level      (line_now),
		.level_prev (line_prev)
	);

	logic scl;
	logic sda;
	logic req;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic [7:0] shifted_in;

	assign scl        = line_now[debug_link_pkg::LINE_SCL];
	assign sda        = line_now[debug_link_pkg::LINE_SDA];
	assign req        = line_now[debug_link_pkg::LINE_REQ];
	// Clock is only ever an input here; edges found by sampling
	assign scl_rise   = scl & ~line_prev[debug_link_pkg::LINE_SCL];
	assign scl_fall   = ~scl & line_prev[debug_link_pkg::LINE_SCL];
	// Needs clock high in both samples so a clock edge is not taken for a start
	assign start_seen = scl & line_prev[debug_link_pkg::LINE_SCL]
		& line_prev[debug_link_pkg::LINE_SDA] & ~sda;
	// Earliest bit ends up in bit 7
	assign shifted_in = {st.shifter[6:0], sda};

	// --------------------------------------------------
	// Phase decodes
	// --------------------------------------------------
	logic byte_in_done;
	logic read_loading;
	logic read_byte_over;
	logic wr_addr_held;
	logic rd_addr_held;
	logic bus_ctl_hit;
	logic grant_open;

	assign byte_in_done   = (st.bit_cnt == debug_link_pkg::LAST_BIT);
	// Read byte loads on its first fall and lets go after the eighth bit
	assign read_loading   = (st.bit_cnt == debug_link_pkg::COUNT_RESET);
	assign read_byte_over = (st.bit_cnt == debug_link_pkg::BITS_PER_BYTE);
	// Counters park at the top of each space
	assign wr_addr_held   = (st.reg_addr == debug_link_pkg::WR_ADDR_LAST);
	assign rd_addr_held   = (st.reg_addr == debug_link_pkg::RD_ADDR_LAST);
	assign bus_ctl_hit    = (st.reg_addr == debug_link_pkg::BUS_CTL_ADDR);
	assign grant_open     = req & st.allow & ~st.busy;

	// --------------------------------------------------
	// Next state
	// --------------------------------------------------
	always_comb begin
		next_st         = st;
		next_st.wr_stb  = 1'b0;
		next_st.rd_stb  = 1'b0;
		next_st.pc_step = 1'b0;

		// Break hold reaches the processor only; this block never gates a clock
		next_st.halt = break_request;

		if (start_seen) begin
			// A start aborts anything in flight, including a read byte
			next_st.fsm     = debug_link_pkg::ST_ADDR;
			next_st.bit_cnt = debug_link_pkg::COUNT_RESET;
			next_st.busy    = 1'b1;
			next_st.sda_out = 1'b0;
			next_st.sda_oe  = 1'b0;
		end else begin
			// Rising data with clock high has no branch of its own
			case (st.fsm)
				// --------------------------------------------------
				// Waiting for a start
				// --------------------------------------------------
				debug_link_pkg::ST_IDLE: begin
					next_st.sda_oe = 1'b0;
				end

				// --------------------------------------------------
				// Address byte and its separator
				// --------------------------------------------------
				debug_link_pkg::ST_ADDR: begin
					if (scl_rise) begin
						next_st.shifter = shifted_in;
						if (byte_in_done) begin
							next_st.reg_addr = shifted_in[7:1];
							next_st.dir_read = shifted_in[0];
							next_st.bit_cnt  = debug_link_pkg::COUNT_RESET;
							next_st.fsm      = debug_link_pkg::ST_ASEP;
						end else begin
							next_st.bit_cnt = st.bit_cnt + 4'h1;
						end
					end
				end
				debug_link_pkg::ST_ASEP: begin
					if (scl_rise) begin
						next_st.busy    = ~sda;
						next_st.bit_cnt = debug_link_pkg::COUNT_RESET;
						if (st.dir_read) begin
							next_st.fsm = debug_link_pkg::ST_RDATA;
						end else begin
							next_st.fsm = debug_link_pkg::ST_WDATA;
						end
					end
				end

				// --------------------------------------------------
				// Write bytes
				// --------------------------------------------------
				debug_link_pkg::ST_WDATA: begin
					if (scl_rise) begin
						next_st.shifter = shifted_in;
						if (byte_in_done) begin
							// Write goes to the write-only space at this address
							next_st.wr_stb  = 1'b1;
							next_st.wr_addr = st.reg_addr;
							next_st.wr_data = shifted_in;
							if (bus_ctl_hit) begin
								next_st.allow = shifted_in[debug_link_pkg::BUS_ALLOW_BIT];
							end
							if (!wr_addr_held) begin
								next_st.reg_addr = st.reg_addr + 7'h01;
							end
							next_st.bit_cnt = debug_link_pkg::COUNT_RESET;
							next_st.fsm     = debug_link_pkg::ST_WSEP;
						end else begin
							next_st.bit_cnt = st.bit_cnt + 4'h1;
						end
					end
				end
				debug_link_pkg::ST_WSEP: begin
					if (scl_rise) begin
						// Ninth clock; either level keeps the write going
						next_st.busy = ~sda;
						next_st.fsm  = debug_link_pkg::ST_WDATA;
					end
				end

				// --------------------------------------------------
				// Read bytes
				// --------------------------------------------------
				debug_link_pkg::ST_RDATA: begin
					if (scl_fall) begin
						if (read_byte_over) begin
							// Separator belongs to the master
							next_st.sda_out = 1'b0;
							next_st.sda_oe  = 1'b0;
							next_st.bit_cnt = debug_link_pkg::COUNT_RESET;
							next_st.fsm     = debug_link_pkg::ST_RSEP;
						end else if (read_loading) begin
							// Read strobe lets the core apply its read side effects
							next_st.rd_stb  = 1'b1;
							next_st.pc_step = 1'b1;
							next_st.shifter = {reg_read_data[6:0], 1'b0};
							next_st.sda_out = reg_read_data[7];
							next_st.sda_oe  = 1'b1;
							next_st.bit_cnt = 4'h1;
						end else begin
							next_st.sda_out = st.shifter[7];
							next_st.shifter = {st.shifter[6:0], 1'b0};
							next_st.bit_cnt = st.bit_cnt + 4'h1;
						end
					end
				end
				debug_link_pkg::ST_RSEP: begin
					if (scl_rise) begin
						next_st.busy = ~sda;
						if (!rd_addr_held) begin
							next_st.reg_addr = st.reg_addr + 7'h01;
						end
						next_st.fsm = debug_link_pkg::ST_RDATA;
					end
				end

				// Unused codes fall back to waiting for a start
				default: begin
					next_st.fsm    = debug_link_pkg::ST_IDLE;
					next_st.sda_oe = 1'b0;
				end
			endcase
		end

		// --------------------------------------------------
		// Bus grant
		// --------------------------------------------------
		// Grant held while request stays, so the bus is not yanked mid-cycle
		if (st.grant) begin
			next_st.grant = req;
		end else begin
			next_st.grant = grant_open;
		end
	end

	// --------------------------------------------------
	// Registers
	// --------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// Line released and grant dropped while reset holds
			st.fsm      <= debug_link_pkg::ST_IDLE;
			st.bit_cnt  <= debug_link_pkg::COUNT_RESET;
			st.shifter  <= debug_link_pkg::BYTE_RESET;
			st.reg_addr <= debug_link_pkg::ADDR_RESET;
			st.dir_read <= 1'b0;
			st.busy     <= 1'b0;
			st.allow    <= 1'b0;
			st.grant    <= 1'b0;
			st.sda_out  <= 1'b0;
			st.sda_oe   <= 1'b0;
			st.wr_stb   <= 1'b0;
			st.wr_addr  <= debug_link_pkg::ADDR_RESET;
			st.wr_data  <= debug_link_pkg::BYTE_RESET;
			st.rd_stb   <= 1'b0;
			st.pc_step  <= 1'b0;
			st.halt     <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// --------------------------------------------------
	// Outputs
	// --------------------------------------------------
	// Link and bus pins
	assign debug_serial_data_out = st.sda_out;
	assign debug_serial_data_oe  = st.sda_oe;
	assign bus_grant_out         = st.grant;

	// Register access
	assign reg_write.strobe      = st.wr_stb;
	assign reg_write.addr        = st.wr_addr;
	assign reg_write.data        = st.wr_data;
	assign reg_read.strobe       = st.rd_stb;
	assign reg_read.addr         = st.reg_addr;

	// Processor and bus status
	assign cpu_halt              = st.halt;
	assign pc_advance_two        = st.pc_step;
	assign bus_grant_allow       = st.allow;
	assign link_busy             = st.busy;

endmodule : two_wire_debug_unit

`default_nettype wire

// [hw/debug_link_pkg.sv]
// Shared constants, state codes and carriers of the two-wire debug slave

package debug_link_pkg;

	// --------------------------------------------------
	// Field widths and counts
	// --------------------------------------------------
	localparam int unsigned  ADDR_W        = 7;
	localparam int unsigned  BYTE_W        = 8;
	localparam logic [3:0]   LAST_BIT      = 4'h7;
	localparam logic [3:0]   BITS_PER_BYTE = 4'h8;

	// --------------------------------------------------
	// Address space limits and control location
	// --------------------------------------------------
	localparam logic [6:0]   WR_ADDR_LAST    = 7'h30;
	localparam logic [6:0]   RD_ADDR_LAST    = 7'h20;
	localparam logic [6:0]   BUS_CTL_ADDR    = 7'h17;
	localparam int unsigned  BUS_ALLOW_BIT   = 7;

	// --------------------------------------------------
	// Reset values
	// --------------------------------------------------
	localparam logic [7:0]   BYTE_RESET  = 8'h00;
	localparam logic [6:0]   ADDR_RESET  = 7'h00;
	localparam logic [3:0]   COUNT_RESET = 4'h0;

	// --------------------------------------------------
	// Sampled line positions
	// --------------------------------------------------
	localparam int unsigned  LINE_COUNT = 3;
	localparam int unsigned  LINE_SCL   = 0;
	localparam int unsigned  LINE_SDA   = 1;
	localparam int unsigned  LINE_REQ   = 2;

	// --------------------------------------------------
	// Protocol states
	// --------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_ASEP  = 7'h04,
		ST_WDATA = 7'h08,
		ST_WSEP  = 7'h10,
		ST_RDATA = 7'h20,
		ST_RSEP  = 7'h40
	} link_state_t;

	// --------------------------------------------------
	// Carriers
	// --------------------------------------------------
	typedef struct packed {
		logic        strobe;
		logic [6:0]  addr;
		logic [7:0]  data;
	} reg_write_t;

	typedef struct packed {
		logic        strobe;
		logic [6:0]  addr;
	} reg_read_t;

endpackage : debug_link_pkg

// [hw/line_sampler.sv]
// Two-stage synchronisers plus a history stage for the serial and bus request pins
`timescale 1ns/1ps
`default_nettype none

module line_sampler (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Raw pins
	input  wire logic [2:0]  raw,
	// Synchronised level and its previous value
	output logic      [2:0]  level,
	output logic      [2:0]  level_prev
);

	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
		logic [2:0] hist;
	} sampler_state_t;

	sampler_state_t st;
	sampler_state_t next_st;

	// --------------------------------------------------
	// Stages
	// --------------------------------------------------
	// Idle lines float high, so stages reset to one
	always_comb begin
		next_st      = st;
		next_st.meta = raw;
		next_st.sync = st.meta;
		next_st.hist = st.sync;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign level      = st.sync;
	assign level_prev = st.hist;

endmodule : line_sampler

`default_nettype wire

// [bench/debug_link_properties.sv]
// Concurrent checks on the debug link slave ports
`timescale 1ns/1ps
`default_nettype none

module debug_link_properties (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       reset,
	// Observed ports
	input wire logic                       debug_serial_data_oe,
	input wire logic                       bus_request_in,
	input wire logic                       bus_grant_out,
	input wire debug_link_pkg::reg_write_t reg_write,
	input wire logic                       break_request,
	input wire logic                       cpu_halt,
	input wire logic                       pc_advance_two,
	input wire logic                       bus_grant_allow,
	input wire logic                       link_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// ----
	// Sequences
	// ----
	sequence s_ctl_write;
		reg_write.strobe && reg_write.addr == debug_link_pkg::BUS_CTL_ADDR
			&& reg_write.data[debug_link_pkg::BUS_ALLOW_BIT];
	endsequence
	sequence s_no_request;
		!bus_request_in [*6];
	endsequence

	// ----
	// Properties
	// ----
	a_halt_tracks_break: assert property (cpu_halt == $past(break_request))
		else $error("halt does not follow break");
	a_allow_by_write: assert property ($rose(bus_grant_allow) |-> s_ctl_write)
		else $error("grant enable set without control write");
	a_grant_needs_allow: assert property ($rose(bus_grant_out) |-> $past(bus_grant_allow) && !$past(link_busy))
		else $error("grant without enable or while busy");
	a_grant_waits_busy: assert property (link_busy && !bus_grant_out |=> !bus_grant_out)
		else $error("grant given during a command");
	a_grant_quits: assert property (s_no_request |=> !bus_grant_out)
		else $error("grant held without request");
	a_write_single_pulse: assert property (reg_write.strobe |=> !reg_write.strobe)
		else $error("write strobe too long");
	a_load_drives_line: assert property (pc_advance_two |-> ##[0:2] debug_serial_data_oe)
		else $error("read load without driving line");
	a_drive_on_load: assert property ($rose(debug_serial_data_oe) |-> pc_advance_two)
		else $error("line driven outside read byte");
	a_advance_one_cycle: assert property (pc_advance_two |=> !pc_advance_two)
		else $error("program counter pulse too long");
endmodule : debug_link_properties

`default_nettype wire

// [bench/debug_link_master.sv]
// Serial master model of the debug link
`timescale 1ns/1ps
`default_nettype none

module debug_link_master (
	// Clock
	input  wire logic clk,
	// Link
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda
);
	// Phase length in clocks, raised for a slow master
	int ph     = 4;
	bit glitch = 1'b0;

	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic wait_ph(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_ph

	task automatic start_cond();
		sda = 1'b1;
		wait_ph(ph);
		sda = 1'b0;
		wait_ph(ph);
	endtask : start_cond

	// Line is released as one, pull-up level, when b is one
	task automatic bit_cycle(input logic b, output logic r);
		scl = 1'b0;
		wait_ph(1);
		sda = b;
		wait_ph(ph - 1);
		scl = 1'b1;
		wait_ph(ph / 2);
		if (glitch && !b)
			sda = 1'b1;
		wait_ph(ph - ph / 2);
		r = sda_wire;
	endtask : bit_cycle

	task automatic byte_cycle(input logic [7:0] d, input logic sep, output logic [7:0] r);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], x);
			r = {r[6:0], x};
		end
		bit_cycle(sep, x);
	endtask : byte_cycle
endmodule : debug_link_master

`default_nettype wire

// [bench/two_wire_debug_unit_test.sv]
// Self-checking bench of the debug link slave
`timescale 1ns/1ps
`default_nettype none

module two_wire_debug_unit_test;
	// ----
	// Signals
	// ----
	logic                       clk   = 1'b0;
	logic                       reset = 1'b1;
	logic                       req   = 1'b0;
	logic                       brk   = 1'b0;
	logic                       scl, sda_m, sda_wire, sda_out, sda_oe, grant, halt, pc, allow, busy;
	debug_link_pkg::reg_write_t wr;
	debug_link_pkg::reg_read_t  rd;
	logic [7:0]                 rdata, r, d;
	logic [6:0]                 a;
	logic [31:0]                seed  = 32'h62f3;
	logic [31:0]                bseed = 32'h62f3;
	logic [14:0]                wq[$];
	int                         fail_count = 0, compares = 0, pcn = 0, rdn = 0;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] rd_val(input logic [6:0] x);
		return {x[0], x} ^ 8'ha5;
	endfunction : rd_val
	function automatic logic [6:0] cap(input logic [6:0] b, input int i, input logic [6:0] lim);
		return (int'(b) + i > int'(lim)) ? lim : 7'(int'(b) + i);
	endfunction : cap

	always #10 clk = ~clk;
	assign sda_wire = sda_oe ? sda_out : sda_m;
	assign rdata    = rd_val(rd.addr);
	always @(negedge clk) begin
		bseed <= lfsr(bseed);
		brk   <= reset ? 1'b0 : bseed[0];
	end
	always @(negedge clk) begin
		if (wr.strobe === 1'b1)
			wq.push_back({wr.addr, wr.data});
		if (pc === 1'b1)
			pcn++;
		if (rd.strobe === 1'b1)
			rdn++;
		if (!reset)
			check(halt === brk, "halt follows break");
	end

	// ----
	// Instances
	// ----
	debug_link_master M (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(sda_m));
	two_wire_debug_unit DUT (.clk(clk), .reset(reset), .debug_serial_clock(scl),
		.debug_serial_data_in(sda_wire), .debug_serial_data_out(sda_out), .debug_serial_data_oe(sda_oe),
		.bus_request_in(req), .bus_grant_out(grant), .reg_write(wr), .reg_read(rd), .reg_read_data(rdata),
		.break_request(brk), .cpu_halt(halt), .pc_advance_two(pc), .bus_grant_allow(allow), .link_busy(busy));

	// ----
	// Tasks
	// ----
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic check(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : check
	task automatic cmd(input logic [6:0] ad, input logic rdir, input logic sep);
		M.start_cond();
		M.byte_cycle({ad, rdir}, sep, r);
	endtask : cmd
	task automatic print_verdict();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	initial begin
		#400000;
		fail_count++;
		print_verdict();
	end

	// ----
	// Scenarios
	// ----
	initial begin
		cyc(10);
		reset = 1'b0;
		cyc(4);
		check(sda_oe === 1'b0 && grant === 1'b0 && allow === 1'b0 && busy === 1'b0, "reset state");
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			a = seed[6:0] % 7'h30;
			if (a == debug_link_pkg::BUS_CTL_ADDR)
				a = 7'h18;
			d = (k == 0) ? 8'h00 : seed[15:8];
			M.glitch = (k == 2);
			cmd(a, 1'b0, 1'b1);
			M.byte_cycle(d, 1'b1, r);
			cyc(6);
			check(wq.size() == 1 && wq[0] === {a, d}, "single write");
			wq.delete();
		end
		M.glitch = 1'b0;
		cmd(7'h2e, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++)
			M.byte_cycle(8'(8'h10 + i), i == 3, r);
		cyc(6);
		check(wq.size() == 4, "block write count");
		for (int i = 0; i < 4; i++)
			check(wq[i] === {cap(7'h2e, i, debug_link_pkg::WR_ADDR_LAST), 8'(8'h10 + i)}, "block write");
		wq.delete();
		// Slow master first: the load must wait for its falling edge
		M.ph = 6;
		seed = lfsr(seed);
		a = seed[6:0] % 7'h21;
		cmd(a, 1'b1, 1'b1);
		M.byte_cycle(8'hff, 1'b1, r);
		check(r === rd_val(a), "single read");
		M.ph = 4;
		pcn = 0;
		rdn = 0;
		cmd(7'h1e, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			M.byte_cycle(8'hff, i == 3, r);
			check(r === rd_val(cap(7'h1e, i, debug_link_pkg::RD_ADDR_LAST)), "block read");
		end
		cyc(4);
		check(pcn == 4 && rdn == 4 && wq.size() == 0 && sda_oe === 1'b0, "read side effects");
		req = 1'b1;
		cyc(10);
		check(grant === 1'b0, "grant before enable");
		cmd(debug_link_pkg::BUS_CTL_ADDR, 1'b0, 1'b0);
		M.byte_cycle(8'h80, 1'b0, r);
		cyc(6);
		check(allow === 1'b1 && grant === 1'b0, "grant held off");
		M.byte_cycle(8'h00, 1'b1, r);
		cyc(6);
		check(grant === 1'b1, "grant after separator");
		req = 1'b0;
		cyc(6);
		check(grant === 1'b0, "grant released");
		print_verdict();
	end
endmodule : two_wire_debug_unit_test

bind two_wire_debug_unit debug_link_properties P (.clk(clk), .reset(reset),
	.debug_serial_data_oe(debug_serial_data_oe), .bus_request_in(bus_request_in), .bus_grant_out(bus_grant_out),
	.reg_write(reg_write), .break_request(break_request), .cpu_halt(cpu_halt), .pc_advance_two(pc_advance_two),
	.bus_grant_allow(bus_grant_allow), .link_busy(link_busy));

`default_nettype wire
